// ==== rtl/kei_pkg.sv ====
// Constants, bus carrier and helper functions for the key edge interrupt unit.
// Assumes a byte-wide CPU register port with byte and single-bit writes.
package kei_pkg;

  localparam int KEI_AW = 20;
  localparam int KEI_DW = 8;
  localparam int KEI_KEYS = 8;

  // Register addresses
  localparam logic [KEI_AW-1:0] KEI_CTRL_ADDR = 20'hFFF34;
  localparam logic [KEI_AW-1:0] KEI_ENA_ADDR = 20'hFFF35;
  localparam logic [KEI_AW-1:0] KEI_FLAG_ADDR = 20'hFFF36;

  // Field positions in key_control
  localparam int KEI_EDGE_BIT = 0;
  localparam int KEI_MODE_BIT = 1;

  // Reset values and masks
  localparam logic [KEI_DW-1:0] KEI_CTRL_RST = 8'h00;
  localparam logic [KEI_DW-1:0] KEI_ENA_RST = 8'h00;
  localparam logic [KEI_DW-1:0] KEI_FLAG_RST = 8'h00;
  localparam logic [KEI_DW-1:0] KEI_CTRL_MASK = 8'h03;
  localparam logic [KEI_DW-1:0] KEI_RD_NONE = 8'h00;
  localparam logic [KEI_DW-1:0] KEI_ZERO = 8'h00;
  localparam logic [KEI_DW-1:0] KEI_ONE = 8'h01;

  // Field encodings
  localparam logic KEI_EDGE_FALL = 1'b0;
  localparam logic KEI_EDGE_RISE = 1'b1;
  localparam logic KEI_FLAGS_OFF = 1'b0;
  localparam logic KEI_FLAGS_ON = 1'b1;

  // Operating mode decoded from key_control
  typedef enum logic [1:0] {
    KEI_MODE_LEVEL = 2'b00,
    KEI_MODE_FLAG = 2'b01,
    KEI_MODE_FLAG_RISE = 2'b10
  } kei_mode_t;

  // One CPU access, all fields valid in the same cycle
  typedef struct packed {
    logic [KEI_AW-1:0] addr;
    logic rd;
    logic wr;
    logic bitWr;
    logic [2:0] bitIdx;
    logic bitVal;
    logic [KEI_DW-1:0] wdata;
  } kei_bus_t;

  // Plain read/write register update for byte and single-bit writes
  function automatic logic [KEI_DW-1:0] kei_rw_next(logic [KEI_DW-1:0] old, kei_bus_t req);
    logic [KEI_DW-1:0] v;
    v = old;
    if (req.wr) begin
      v = req.wdata;
    end else if (req.bitWr) begin
      v[req.bitIdx] = req.bitVal;
    end
    return v;
  endfunction : kei_rw_next

  // Bits that a write to the flag register clears; ones never set anything
  function automatic logic [KEI_DW-1:0] kei_clr_mask(kei_bus_t req);
    logic [KEI_DW-1:0] m;
    m = KEI_ZERO;
    if (req.wr) begin
      m = ~req.wdata;
    end else if (req.bitWr && !req.bitVal) begin
      m = KEI_ONE << req.bitIdx;
    end
    return m;
  endfunction : kei_clr_mask

  // Lowest set bit as a one-hot vector
  function automatic logic [KEI_DW-1:0] kei_lowest(logic [KEI_DW-1:0] v);
    return v & (~v + KEI_ONE);
  endfunction : kei_lowest

endpackage : kei_pkg

// ==== rtl/kei_sync.sv ====
// Two-stage synchroniser for the key input pins.
// Assumes the pins are asynchronous to clk; no filtering is done here.
`timescale 1ns/10ps
module kei_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  // First stage feeds only the second stage
  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end

endmodule : kei_sync

// ==== rtl/kei_edge.sv ====
// Edge finder on the qualified active levels of the key channels.
// Assumes act is already synchronous to clk and gated by the channel enables.
`timescale 1ns/10ps
module kei_edge #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] act,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] actPrev;
  logic [WIDTH-1:0] next_actPrev;

  // Previous sample of the active level
  always_comb begin
    next_actPrev = act;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      actPrev <= '0;
    end else begin
      actPrev <= next_actPrev;
    end
  end

  // Enabling a channel already at its active level also counts as an edge
  assign rise = act & ~actPrev;

  property p_edge_once;
    @(posedge clk) disable iff (!arst_n)
    (rise != '0) |=> ((rise & $past(rise)) == '0);
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("key edge reported twice in a row");

endmodule : kei_edge

// ==== rtl/kei_top.sv ====
// Key edge interrupt unit: eight key inputs, one combined request.
// Assumes a single-cycle CPU register port (kei_bus_t) on clk, and key pins
// that are asynchronous and already configured as inputs elsewhere.
`timescale 1ns/10ps
module kei_top
  import kei_pkg::*;
#(
  parameter logic [KEI_AW-1:0] ENA_ADDR = KEI_ENA_ADDR,
  parameter logic [KEI_AW-1:0] FLAG_ADDR = KEI_FLAG_ADDR
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire kei_bus_t busReq,
  input wire logic [KEI_KEYS-1:0] keyPins,
  output logic [KEI_DW-1:0] rdData,
  output logic keyIrq
);

  // Register state
  logic [KEI_DW-1:0] ctrl;
  logic [KEI_DW-1:0] next_ctrl;
  logic [KEI_DW-1:0] keyEna;
  logic [KEI_DW-1:0] next_keyEna;
  logic [KEI_DW-1:0] flags;
  logic [KEI_DW-1:0] next_flags;
  logic [KEI_DW-1:0] pending;
  logic [KEI_DW-1:0] next_pending;
  logic [KEI_DW-1:0] next_rdData;
  logic next_keyIrq;

  // Detection path
  logic [KEI_KEYS-1:0] keySync;
  logic [KEI_KEYS-1:0] act;
  logic [KEI_KEYS-1:0] keyEvent;
  logic anyActive;
  logic edgeRise;
  logic flagsOn;
  kei_mode_t mode;

  // Access decode and flag scheduling
  logic selCtrl;
  logic selEna;
  logic selFlag;
  logic [KEI_DW-1:0] clrMask;
  logic [KEI_DW-1:0] cand;
  logic [KEI_DW-1:0] pick;
  logic [KEI_DW-1:0] kept;

  kei_sync #(
    .WIDTH(KEI_KEYS)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(keyPins),
    .dout(keySync)
  );

  // Control fields
  assign edgeRise = ctrl[KEI_EDGE_BIT] == KEI_EDGE_RISE;
  assign flagsOn = ctrl[KEI_MODE_BIT] == KEI_FLAGS_ON;

  // Active level per channel; disabled pins are forced inactive
  assign act = keyEna & (edgeRise ? keySync : ~keySync);
  assign anyActive = |act;

  kei_edge #(
    .WIDTH(KEI_KEYS)
  ) u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .act(act),
    .rise(keyEvent)
  );

  // Mode decode; rising edge with flags is undefined, so it runs as flag mode with rising select (KEI_MODE_FLAG_RISE)
  always_comb begin
    case ({flagsOn, edgeRise})
      2'b00: mode = KEI_MODE_LEVEL;
      2'b01: mode = KEI_MODE_LEVEL;
      2'b10: mode = KEI_MODE_FLAG;
      2'b11: mode = KEI_MODE_FLAG_RISE;
      default: mode = KEI_MODE_LEVEL;
    endcase
  end

  // Address decode
  assign selCtrl = busReq.addr == KEI_CTRL_ADDR;
  assign selEna = busReq.addr == ENA_ADDR;
  assign selFlag = busReq.addr == FLAG_ADDR;

  // Flag clears only count while flags are in use; otherwise the access is ignored
  assign clrMask = (selFlag && flagsOn) ? kei_clr_mask(busReq) : KEI_ZERO;

  // Register writes; reserved control bits are never stored
  always_comb begin
    next_ctrl = ctrl;
    next_keyEna = keyEna;
    if (selCtrl) begin
      next_ctrl = kei_rw_next(ctrl, busReq) & KEI_CTRL_MASK;
    end
    if (selEna) begin
      next_keyEna = kei_rw_next(keyEna, busReq);
    end
  end

  // Flag scheduling: new edges not promoted at once queue as pending, one flag stands at a time.
  // Promotion waits for a cycle with no flag so the request falls and rises
  // again, which gives the CPU a fresh edge for each queued channel.
  always_comb begin
    cand = pending | keyEvent;
    kept = flags & ~clrMask;
    pick = KEI_ZERO;
    next_flags = kept;
    next_pending = cand;
    if (!flagsOn) begin
      next_flags = KEI_ZERO;
      next_pending = KEI_ZERO;
    end else if (flags == KEI_ZERO) begin
      pick = kei_lowest(cand);
      next_flags = kept | pick;
      next_pending = cand & ~pick;
    end
  end

  // Combined request, chosen by mode
  always_comb begin
    case (mode)
      KEI_MODE_LEVEL: next_keyIrq = anyActive;
      KEI_MODE_FLAG: next_keyIrq = |next_flags;
      KEI_MODE_FLAG_RISE: next_keyIrq = |next_flags;
      default: next_keyIrq = 1'b0;
    endcase
  end

  // Read data; unmapped addresses read zero, reads see the value before a same-cycle write
  always_comb begin
    next_rdData = rdData;
    if (busReq.rd) begin
      if (selCtrl) begin
        next_rdData = ctrl;
      end else if (selEna) begin
        next_rdData = keyEna;
      end else if (selFlag) begin
        next_rdData = flags;
      end else begin
        next_rdData = KEI_RD_NONE;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= KEI_CTRL_RST;
      keyEna <= KEI_ENA_RST;
      flags <= KEI_FLAG_RST;
      pending <= KEI_ZERO;
      rdData <= KEI_RD_NONE;
      keyIrq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      keyEna <= next_keyEna;
      flags <= next_flags;
      pending <= next_pending;
      rdData <= next_rdData;
      keyIrq <= next_keyIrq;
    end
  end

  // Checks

  property p_reset_vals;
    @(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> (ctrl == KEI_CTRL_RST) && (keyEna == KEI_ENA_RST) && (flags == KEI_FLAG_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("registers not cleared by reset");

  property p_ctrl_write;
    @(posedge clk) disable iff (!arst_n)
    (selCtrl && busReq.wr) |=> (ctrl == ($past(busReq.wdata) & KEI_CTRL_MASK));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control byte write lost");

  property p_ena_bit_write;
    @(posedge clk) disable iff (!arst_n)
    (selEna && busReq.bitWr && !busReq.wr) |=> (keyEna[$past(busReq.bitIdx)] == $past(busReq.bitVal));
  endproperty
  a_ena_bit_write: assert property (p_ena_bit_write) else $error("enable bit write lost");

  property p_disabled_quiet;
    @(posedge clk) disable iff (!arst_n)
    ((keyEvent & ~keyEna) == '0) && ((act & ~keyEna) == '0);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled channel detected");

  property p_level_irq;
    @(posedge clk) disable iff (!arst_n)
    ($past(mode) == KEI_MODE_LEVEL) |-> (keyIrq == $past(anyActive));
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level request does not follow pins");

  property p_flag_irq;
    @(posedge clk) disable iff (!arst_n)
    ($past(flagsOn) && flagsOn) |-> (keyIrq == (flags != KEI_ZERO));
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag request does not follow flags");

  property p_flags_off;
    @(posedge clk) disable iff (!arst_n)
    !flagsOn |=> (flags == KEI_ZERO) && (pending == KEI_ZERO);
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("flags set while unused");

  property p_one_flag;
    @(posedge clk) disable iff (!arst_n)
    $onehot0(flags);
  endproperty
  a_one_flag: assert property (p_one_flag) else $error("more than one flag standing");

  property p_next_flag;
    @(posedge clk) disable iff (!arst_n)
    (flagsOn && (flags == KEI_ZERO) && (pending != KEI_ZERO)) |=> (flags != KEI_ZERO) ##1 1'b1;
  endproperty
  a_next_flag: assert property (p_next_flag) else $error("pending edge not promoted");

  property p_write_one;
    @(posedge clk) disable iff (!arst_n)
    (flagsOn && selFlag && busReq.bitWr && !busReq.wr && busReq.bitVal) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_write_one: assert property (p_write_one) else $error("writing one changed a flag");

  property p_write_zero;
    @(posedge clk) disable iff (!arst_n)
    (flagsOn && selFlag && busReq.wr && (flags != KEI_ZERO)) |=> ((flags & ~$past(busReq.wdata)) == KEI_ZERO);
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("writing zero left a flag set");

  // Register access: writes land at the taking edge, reads answer one cycle later

  property p_ena_write;
    @(posedge clk) disable iff (!arst_n)
    (selEna && busReq.wr) |=> (keyEna == $past(busReq.wdata));
  endproperty
  a_ena_write: assert property (p_ena_write) else $error("enable byte write lost");

  property p_ctrl_bit_write;
    @(posedge clk) disable iff (!arst_n)
    (selCtrl && busReq.bitWr && !busReq.wr && (busReq.bitIdx <= 3'(KEI_MODE_BIT))) |=>
      (ctrl[$past(busReq.bitIdx)] == $past(busReq.bitVal));
  endproperty
  a_ctrl_bit_write: assert property (p_ctrl_bit_write) else $error("control bit write lost");

  property p_ctrl_reserved;
    @(posedge clk) disable iff (!arst_n)
    (ctrl & ~KEI_CTRL_MASK) == KEI_ZERO;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bit stored");

  property p_rd_ctrl;
    @(posedge clk) disable iff (!arst_n)
    (busReq.rd && selCtrl) |=> (rdData == $past(ctrl));
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read returned wrong data");

  property p_rd_ena;
    @(posedge clk) disable iff (!arst_n)
    (busReq.rd && selEna) |=> (rdData == $past(keyEna));
  endproperty
  a_rd_ena: assert property (p_rd_ena) else $error("enable read returned wrong data");

  property p_rd_flag;
    @(posedge clk) disable iff (!arst_n)
    (busReq.rd && selFlag) |=> (rdData == $past(flags));
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("flag read returned wrong data");

  // Read data must stand between reads, software may sample it late
  property p_rd_hold;
    @(posedge clk) disable iff (!arst_n)
    !busReq.rd |=> $stable(rdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");

  // Only checked while a flag stands, since a promotion may refill the bit
  property p_flag_bit_clear;
    @(posedge clk) disable iff (!arst_n)
    (flagsOn && selFlag && busReq.bitWr && !busReq.wr && !busReq.bitVal && (flags != KEI_ZERO)) |=>
      !flags[$past(busReq.bitIdx)];
  endproperty
  a_flag_bit_clear: assert property (p_flag_bit_clear) else $error("bit clear left a flag set");

  property p_clear_drop;
    @(posedge clk) disable iff (!arst_n)
    (flagsOn && (flags != KEI_ZERO) && (kept == KEI_ZERO)) |=> !keyIrq;
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("request stayed up after flag clear");

  // A flag may only appear for a channel that saw an edge or was queued
  property p_flag_source;
    @(posedge clk) disable iff (!arst_n)
    (flags & ~$past(flags) & ~$past(pending) & ~$past(keyEvent)) == KEI_ZERO;
  endproperty
  a_flag_source: assert property (p_flag_source) else $error("flag set without an edge");

endmodule : kei_top

// ==== testbench/kei_key_model.sv ====
// Key switch model for the key input pins: one switch per channel to ground.
// Assumes pull-ups on every pin, so a released key reads high and a pressed key low.
`timescale 1ns/10ps
module kei_key_model #(
  parameter int SETTLE_NS = 0
) (
  input wire logic [7:0] pressed,
  output logic [7:0] keyPins
);
  // Pull-up holds released pins high; SETTLE_NS lets a slow switch be modelled
  // Continuous drive, so the level set at time zero reaches the pins without a race
  assign #(SETTLE_NS) keyPins = ~pressed;
endmodule : kei_key_model

// ==== testbench/tb_key_edge_interrupt.sv ====
// Testbench for the key edge interrupt unit: register access, level and flag modes.
// Assumes kei_top with its default addresses and the key switch model on its pins.
`timescale 1ns/10ps
module tb_key_edge_interrupt;
  import kei_pkg::*;
  logic clk;
  logic arst_n;
  kei_bus_t busReq;
  logic [KEI_KEYS-1:0] pressed;
  logic [KEI_KEYS-1:0] keyPins;
  logic [KEI_DW-1:0] rdData;
  logic keyIrq;
  int failures = 0;
  int checkCount = 0;
  int cycles = 0;

  kei_top u_dut (.clk(clk), .arst_n(arst_n), .busReq(busReq), .keyPins(keyPins), .rdData(rdData), .keyIrq(keyIrq));
  kei_key_model u_keys (.pressed(pressed), .keyPins(keyPins));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard; the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (failures == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk_byte(input logic [KEI_DW-1:0] got, input logic [KEI_DW-1:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_irq(input logic exp);
    checkCount++;
    if (keyIrq !== exp) begin
      failures++;
      $display("[FAIL] t=%0t irq got=%h exp=%h", $time, keyIrq, exp);
    end
  endtask : chk_irq

  // One bus cycle, held across one sampling edge, then an idle cycle boundary
  task automatic access(input kei_bus_t r);
    @(posedge clk);
    #1 busReq = r;
    @(posedge clk);
    #1 busReq = '0;
  endtask : access

  task automatic wr(input logic [KEI_AW-1:0] a, input logic [KEI_DW-1:0] d);
    kei_bus_t r;
    r = '0;
    r.addr = a;
    r.wr = 1'b1;
    r.wdata = d;
    access(r);
  endtask : wr

  task automatic bwr(input logic [KEI_AW-1:0] a, input logic [2:0] idx, input logic v);
    kei_bus_t r;
    r = '0;
    r.addr = a;
    r.bitWr = 1'b1;
    r.bitIdx = idx;
    r.bitVal = v;
    access(r);
  endtask : bwr

  // Read data is due right after the edge that takes the request
  task automatic rd(input logic [KEI_AW-1:0] a, input logic [KEI_DW-1:0] exp);
    kei_bus_t r;
    r = '0;
    r.addr = a;
    r.rd = 1'b1;
    access(r);
    chk_byte(rdData, exp);
  endtask : rd

  // Pin to request takes two sync stages and the output register
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  initial begin
    arst_n = 1'b0;
    busReq = '0;
    pressed = 8'h00;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(KEI_CTRL_ADDR, KEI_CTRL_RST);
    rd(KEI_ENA_ADDR, KEI_ENA_RST);
    rd(KEI_FLAG_ADDR, KEI_FLAG_RST);
    rd(20'h00100, KEI_RD_NONE);
    wr(KEI_CTRL_ADDR, 8'hFF);
    rd(KEI_CTRL_ADDR, KEI_CTRL_MASK);
    bwr(KEI_CTRL_ADDR, 3'h0, 1'b0);
    rd(KEI_CTRL_ADDR, 8'h02);
    bwr(KEI_CTRL_ADDR, 3'h1, 1'b0);
    rd(KEI_CTRL_ADDR, 8'h00);
    // Level mode, falling: only the enabled channel may raise the request
    for (int i = 0; i < KEI_KEYS; i++) begin
      bwr(KEI_ENA_ADDR, 3'(i), 1'b1);
      pressed = ~(8'h01 << i);
      settle();
      chk_irq(1'b0);
      pressed = 8'hFF;
      settle();
      chk_irq(1'b1);
      pressed = 8'h00;
      settle();
      chk_irq(1'b0);
      bwr(KEI_ENA_ADDR, 3'(i), 1'b0);
    end
    // Overlapping presses keep one request standing
    wr(KEI_ENA_ADDR, 8'h03);
    pressed = 8'h01;
    settle();
    chk_irq(1'b1);
    pressed = 8'h03;
    settle();
    pressed = 8'h02;
    settle();
    chk_irq(1'b1);
    pressed = 8'h00;
    settle();
    chk_irq(1'b0);
    // Enabling a channel whose key is already down raises the level request
    wr(KEI_ENA_ADDR, 8'h00);
    pressed = 8'h04;
    settle();
    chk_irq(1'b0);
    wr(KEI_ENA_ADDR, 8'h04);
    settle();
    chk_irq(1'b1);
    // Rising select: a released key (high) is the active level
    wr(KEI_CTRL_ADDR, 8'h01);
    settle();
    chk_irq(1'b0);
    pressed = 8'h00;
    settle();
    chk_irq(1'b1);
    wr(KEI_ENA_ADDR, 8'h00);
    // Flag mode, falling: one flag at a time, next flag one clock after a clear
    wr(KEI_CTRL_ADDR, 8'h02);
    wr(KEI_ENA_ADDR, 8'hFF);
    pressed = 8'h01;
    settle();
    chk_irq(1'b1);
    rd(KEI_FLAG_ADDR, 8'h01);
    pressed = 8'h03;
    settle();
    pressed = 8'h02;
    wr(KEI_FLAG_ADDR, 8'hFF);
    rd(KEI_FLAG_ADDR, 8'h01);
    chk_irq(1'b1);
    wr(KEI_FLAG_ADDR, 8'hFE);
    chk_irq(1'b0);
    @(posedge clk);
    #1 chk_irq(1'b1);
    rd(KEI_FLAG_ADDR, 8'h02);
    bwr(KEI_FLAG_ADDR, 3'h1, 1'b0);
    chk_irq(1'b0);
    settle();
    chk_irq(1'b0);
    rd(KEI_FLAG_ADDR, 8'h00);
    // Flags with rising select: a release (high) sets the flag
    wr(KEI_ENA_ADDR, 8'h00);
    wr(KEI_CTRL_ADDR, 8'h03);
    pressed = 8'hFF;
    settle();
    wr(KEI_ENA_ADDR, 8'h01);
    settle();
    chk_irq(1'b0);
    pressed = 8'hFE;
    settle();
    chk_irq(1'b1);
    rd(KEI_FLAG_ADDR, 8'h01);
    bwr(KEI_FLAG_ADDR, 3'h0, 1'b1);
    rd(KEI_FLAG_ADDR, 8'h01);
    // Turning flag usage off drops the standing flag; the level path takes over
    wr(KEI_CTRL_ADDR, 8'h01);
    rd(KEI_FLAG_ADDR, KEI_FLAG_RST);
    chk_irq(1'b1);
    complete_run();
  end
endmodule : tb_key_edge_interrupt
